// file: logic/baud_port_pkg.sv
// Package for the baud divisor and board signal port block.
// Assumes a 40 MHz system clock and a 32-bit AHB-Lite register bus.
package baud_port_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Register byte offsets (low address byte only)
  localparam logic [7:0] PORT_OFFSET       = 8'h00;
  localparam logic [7:0] PORT_CONFIG_OFFSET = 8'h04;
  localparam logic [7:0] INT_PORT_OFFSET   = 8'h08;
  localparam logic [7:0] LOOPBACK_OFFSET   = 8'h0c;
  localparam logic [7:0] CHANNEL_BASE      = 8'h20;
  localparam logic [7:0] CHANNEL_STRIDE    = 8'h20;
  localparam logic [7:0] CONFIG_ONE_OFFSET = 8'h00;
  localparam logic [7:0] CONFIG_TWO_OFFSET = 8'h04;
  localparam logic [7:0] CONFIG_FOUR_OFFSET = 8'h08;
  localparam logic [7:0] DIVISOR_LOW_OFFSET = 8'h0c;
  localparam logic [7:0] STATUS_OFFSET     = 8'h10;

  //////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int SYNTH_DATA_BIT    = 0;
  localparam int SYNTH_CLOCK_BIT   = 1;
  localparam int SYNTH_STROBE_BIT  = 2;
  localparam int DTR_FIRST_BIT     = 3;
  localparam int DSR_FIRST_BIT     = 5;
  localparam int OVERSAMPLE_BIT    = 3;
  localparam int DIVISOR_ENABLE_BIT = 5;
  localparam int ENHANCED_BIT      = 6;

  //////////////////////////////////////////////////////////////////////////////
  // Reset values, masks and counts
  localparam logic [7:0]  REG_RESET         = 8'h00;
  localparam logic [7:0]  PORT_WRITE_MASK   = 8'h1f;
  localparam logic [3:0]  LOOPBACK_MASK     = 4'hf;
  localparam logic [3:0]  OVERSAMPLE_LAST   = 4'hf;
  localparam int          CHANNELS          = 2;
  localparam int          DIV_W             = 22;
  localparam logic [21:0] DIVISOR_BYPASS    = 22'h000001;
  localparam logic [21:0] DIVISOR_ALIASED   = 22'h000002;

  typedef enum logic [0:0] {BUS_IDLE, BUS_READ_WAIT} bus_state_t;

  // Effective generator divisor from the three configuration bytes
  function automatic logic [21:0] compute_divisor(input logic [7:0] config_two,
                                                  input logic [7:0] config_four,
                                                  input logic [7:0] divisor_low);
    logic [10:0] n_plus_one;
    logic [21:0] mantissa;
    logic [3:0]  exponent;
    n_plus_one = {1'b0, config_two[7:6], divisor_low} + 11'h001;
    mantissa   = {16'h0000, divisor_low[5:0]} + 22'h000001;
    exponent   = {config_two[7:6], divisor_low[7:6]};
    if (!config_two[DIVISOR_ENABLE_BIT]) begin
      compute_divisor = DIVISOR_BYPASS;
    end else if (config_four[ENHANCED_BIT]) begin
      compute_divisor = mantissa << exponent;
    end else if (divisor_low[5:0] == 6'h00) begin
      compute_divisor = DIVISOR_ALIASED;
    end else begin
      compute_divisor = {10'h000, n_plus_one, 1'b0};
    end
  endfunction

endpackage

// file: logic/baud_port_map.sv
// Baud divisor generators for two channels, board signal port and loopback.
// Assumes an AHB-Lite master with word transfers and a synchronous
// oscillator level on oscillator_input_i, sampled on clock_i.
module baud_port_map
  import baud_port_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        resetn_i,
  // AHB-Lite slave
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // Oscillator from the frequency synthesizer
  input  wire logic        oscillator_input_i,
  // Board signal port pins
  output logic             synth_data_o,
  output logic             synth_clock_o,
  output logic             synth_strobe_o,
  output logic      [1:0]  dtr_o,
  input  wire logic [1:0]  dsr_i,
  // Generator outputs per channel
  output logic      [1:0]  baud_tick_o,
  output logic      [1:0]  bit_tick_o,
  // Line side per channel
  input  wire logic [1:0]  tx_pos_i,
  input  wire logic [1:0]  tx_neg_i,
  input  wire logic [1:0]  tx_drive_i,
  input  wire logic [1:0]  line_rx_pos_i,
  input  wire logic [1:0]  line_rx_neg_i,
  output logic      [1:0]  line_tx_pos_o,
  output logic      [1:0]  line_tx_neg_o,
  output logic      [1:0]  line_driver_enable_o,
  output logic      [1:0]  line_receiver_enable_o,
  output logic      [1:0]  rx_pos_o,
  output logic      [1:0]  rx_neg_o
);

  //////////////////////////////////////////////////////////////////////////////
  // Register storage
  logic [7:0]  board_signal_port;
  logic [7:0]  port_config_register;
  logic [7:0]  interrupt_port_config;
  logic [3:0]  loopback_switch;
  logic [7:0]  channel_config_one    [CHANNELS];
  logic [7:0]  channel_config_two    [CHANNELS];
  logic [7:0]  channel_config_four   [CHANNELS];
  logic [7:0]  divisor_low_register  [CHANNELS];
  logic [15:0] bit_count             [CHANNELS];

  // Bus phase tracking
  bus_state_t  bus_state;
  logic        write_pending;
  logic [7:0]  write_addr;
  logic [7:0]  read_addr;
  logic        addr_phase;

  // Oscillator edge detect
  logic        osc_last;
  logic        osc_rise;

  //////////////////////////////////////////////////////////////////////////////
  // Address decoding helpers
  function automatic logic is_channel(input logic [7:0] addr, input int ch);
    logic [7:0] base;
    base = CHANNEL_BASE + 8'(ch) * CHANNEL_STRIDE;
    is_channel = (addr >= base) && (addr < base + CHANNEL_STRIDE);
  endfunction

  function automatic logic [7:0] channel_offset(input logic [7:0] addr, input int ch);
    channel_offset = addr - (CHANNEL_BASE + 8'(ch) * CHANNEL_STRIDE);
  endfunction

  // Closed switch position picks the local transmit level over the line
  function automatic logic loop_select(input logic closed, input logic tx, input logic line);
    loop_select = closed ? tx : line;
  endfunction

  assign addr_phase = hsel_i && htrans_i[1] && hready_i;
  assign osc_rise   = oscillator_input_i && !osc_last;

  //////////////////////////////////////////////////////////////////////////////
  // AHB-Lite control: writes take no wait state, reads take one
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      bus_state     <= BUS_IDLE;
      write_pending <= 1'b0;
      write_addr    <= 8'h00;
      read_addr     <= 8'h00;
      hreadyout_o   <= 1'b1;
      hresp_o       <= 1'b0;
    end else begin
      hresp_o       <= 1'b0;
      write_pending <= addr_phase && hwrite_i;
      unique case (bus_state)
        BUS_IDLE: begin
          if (addr_phase && hwrite_i) begin
            write_addr <= haddr_i[7:0];
          end else if (addr_phase) begin
            // Wait state lets a preceding write land first
            read_addr   <= haddr_i[7:0];
            hreadyout_o <= 1'b0;
            bus_state   <= BUS_READ_WAIT;
          end
        end
        BUS_READ_WAIT: begin
          hreadyout_o <= 1'b1;
          bus_state   <= BUS_IDLE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read data
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      hrdata_o <= 32'h00000000;
    end else if (bus_state == BUS_READ_WAIT) begin
      hrdata_o <= 32'h00000000;
      unique case (read_addr)
        PORT_OFFSET: begin
          // Top bit reads as zero, DSR bits reflect pins
          hrdata_o[7:0] <= {1'b0, dsr_i, board_signal_port[4:0]};
        end
        PORT_CONFIG_OFFSET: hrdata_o[7:0] <= port_config_register;
        INT_PORT_OFFSET:    hrdata_o[7:0] <= interrupt_port_config;
        LOOPBACK_OFFSET:    hrdata_o[3:0] <= loopback_switch;
        default: begin
          for (int c = 0; c < CHANNELS; c++) begin
            if (is_channel(read_addr, c)) begin
              unique case (channel_offset(read_addr, c))
                CONFIG_ONE_OFFSET:  hrdata_o[7:0]  <= channel_config_one[c];
                CONFIG_TWO_OFFSET:  hrdata_o[7:0]  <= channel_config_two[c];
                CONFIG_FOUR_OFFSET: hrdata_o[7:0]  <= channel_config_four[c];
                DIVISOR_LOW_OFFSET: hrdata_o[7:0]  <= divisor_low_register[c];
                STATUS_OFFSET:      hrdata_o[15:0] <= bit_count[c];
                default:            hrdata_o       <= 32'h00000000;
              endcase
            end
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Shared register writes
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      board_signal_port     <= REG_RESET;
      port_config_register  <= REG_RESET;
      interrupt_port_config <= REG_RESET;
      loopback_switch       <= 4'h0;
    end else if (write_pending) begin
      unique case (write_addr)
        PORT_OFFSET:        board_signal_port     <= hwdata_i[7:0] & PORT_WRITE_MASK;
        PORT_CONFIG_OFFSET: port_config_register  <= hwdata_i[7:0];
        INT_PORT_OFFSET:    interrupt_port_config <= hwdata_i[7:0];
        LOOPBACK_OFFSET:    loopback_switch       <= hwdata_i[3:0] & LOOPBACK_MASK;
        default:            board_signal_port     <= board_signal_port;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Board signal port pins, driven from the stored bits
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      synth_data_o   <= 1'b0;
      synth_clock_o  <= 1'b0;
      synth_strobe_o <= 1'b0;
    end else begin
      // Synthesizer loaded purely by software toggling these bits
      synth_data_o   <= board_signal_port[SYNTH_DATA_BIT];
      synth_clock_o  <= board_signal_port[SYNTH_CLOCK_BIT];
      synth_strobe_o <= board_signal_port[SYNTH_STROBE_BIT];
    end
  end

  // DTR levels are plain register copies, no handshake behind them
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      dtr_o <= 2'b00;
    end else begin
      dtr_o <= board_signal_port[DTR_FIRST_BIT +: 2];
    end
  end

  // Reset low to match the idle oscillator level, so no false edge
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      osc_last <= 1'b0;
    end else begin
      osc_last <= oscillator_input_i;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Per-channel configuration, generator and line switching
  for (genvar c = 0; c < CHANNELS; c++) begin : g_channel
    logic [DIV_W-1:0] divisor;
    logic [DIV_W-1:0] div_count;
    logic [3:0]       ovs_count;
    logic             gen_tick;
    logic             bit_tick;

    always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
        channel_config_one[c]   <= REG_RESET;
        channel_config_two[c]   <= REG_RESET;
        channel_config_four[c]  <= REG_RESET;
        divisor_low_register[c] <= REG_RESET;
      end else if (write_pending && is_channel(write_addr, c)) begin
        unique case (channel_offset(write_addr, c))
          CONFIG_ONE_OFFSET:  channel_config_one[c]   <= hwdata_i[7:0];
          CONFIG_TWO_OFFSET:  channel_config_two[c]   <= hwdata_i[7:0];
          CONFIG_FOUR_OFFSET: channel_config_four[c]  <= hwdata_i[7:0];
          DIVISOR_LOW_OFFSET: divisor_low_register[c] <= hwdata_i[7:0];
          default:            channel_config_one[c]   <= channel_config_one[c];
        endcase
      end
    end

    // Divisor selection covers bypass, aliasing, standard and enhanced forms
    assign divisor = compute_divisor(channel_config_two[c], channel_config_four[c],
                                     divisor_low_register[c]);

    // Counts oscillator edges; wraps early if the divisor shrinks mid-count
    assign gen_tick = osc_rise && (div_count >= divisor - DIVISOR_BYPASS);

    always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
        div_count <= '0;
      end else if (osc_rise) begin
        div_count <= gen_tick ? '0 : div_count + DIVISOR_BYPASS;
      end
    end

    always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
        ovs_count <= 4'h0;
      end else if (gen_tick) begin
        ovs_count <= ovs_count + 4'h1;
      end
    end

    assign bit_tick = channel_config_one[c][OVERSAMPLE_BIT]
                    ? (gen_tick && ovs_count == OVERSAMPLE_LAST)
                    : gen_tick;

    // Registered ticks, one cycle per generator or bit event
    always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
        baud_tick_o[c] <= 1'b0;
        bit_tick_o[c]  <= 1'b0;
      end else begin
        baud_tick_o[c] <= gen_tick;
        bit_tick_o[c]  <= bit_tick;
      end
    end

    // Bit time count, visible as a read-only status word
    always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
        bit_count[c] <= 16'h0000;
      end else if (bit_tick) begin
        bit_count[c] <= bit_count[c] + 16'h0001;
      end
    end

    // Line side: transmit pair passes straight to the drivers
    always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
        line_tx_pos_o[c] <= 1'b0;
        line_tx_neg_o[c] <= 1'b0;
      end else begin
        line_tx_pos_o[c] <= tx_pos_i[c];
        line_tx_neg_o[c] <= tx_neg_i[c];
      end
    end

    // Controller alone decides when it owns the shared pair
    always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
        line_driver_enable_o[c] <= 1'b0;
      end else begin
        line_driver_enable_o[c] <= tx_drive_i[c];
      end
    end

    // Receivers never gated, so a station hears its own transmission
    always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
        line_receiver_enable_o[c] <= 1'b1;
      end else begin
        line_receiver_enable_o[c] <= 1'b1;
      end
    end

    // Loopback per switch position; a closed switch wins over the line
    always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
        rx_pos_o[c] <= 1'b0;
        rx_neg_o[c] <= 1'b0;
      end else begin
        rx_pos_o[c] <= loop_select(loopback_switch[2*c], tx_pos_i[c], line_rx_pos_i[c]);
        rx_neg_o[c] <= loop_select(loopback_switch[2*c+1], tx_neg_i[c], line_rx_neg_i[c]);
      end
    end
  end

endmodule

// file: tb/baud_port_map_asserts.sv
// Checker for the baud divisor and board port block.
// Bound to baud_port_map; sees its ports only.
module baud_port_map_asserts
  import baud_port_pkg::*;
(
  input wire logic        clock_i,
  input wire logic        resetn_i,
  input wire logic        hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0]  htrans_i,
  input wire logic        hwrite_i,
  input wire logic [31:0] hwdata_i,
  input wire logic        hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic        hreadyout_o,
  input wire logic        oscillator_input_i,
  input wire logic        synth_data_o,
  input wire logic        synth_clock_o,
  input wire logic        synth_strobe_o,
  input wire logic [1:0]  dtr_o,
  input wire logic [1:0]  baud_tick_o,
  input wire logic [1:0]  bit_tick_o,
  input wire logic [1:0]  tx_pos_i,
  input wire logic [1:0]  tx_neg_i,
  input wire logic [1:0]  line_rx_pos_i,
  input wire logic [1:0]  line_rx_neg_i,
  input wire logic [1:0]  line_receiver_enable_o,
  input wire logic [1:0]  rx_pos_o,
  input wire logic [1:0]  rx_neg_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic       take, wp, wl, rd0, rd1, osc_q;
  logic [4:0] port_m, port_q;
  logic [3:0] loop_m, hist;
  logic [1:0] exp_p, exp_n;
  assign take = hsel_i & htrans_i[1] & hready_i;
  // Mirrors of the port and loopback registers, fed from the bus
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      {wp, wl, rd0, rd1, osc_q, port_m, port_q, loop_m, hist, exp_p, exp_n} <= '0;
    end else begin
      wp <= take & hwrite_i & (haddr_i[7:0] == PORT_OFFSET);
      wl <= take & hwrite_i & (haddr_i[7:0] == LOOPBACK_OFFSET);
      rd0 <= take & !hwrite_i & (haddr_i[7:0] == PORT_OFFSET);
      rd1 <= rd0;
      if (wp & hready_i) port_m <= hwdata_i[4:0];
      if (wl & hready_i) loop_m <= hwdata_i[3:0];
      port_q <= port_m;
      osc_q <= oscillator_input_i;
      hist <= {hist[2:0], oscillator_input_i & ~osc_q};
      exp_p <= ({loop_m[2], loop_m[0]} & tx_pos_i) | (~{loop_m[2], loop_m[0]} & line_rx_pos_i);
      exp_n <= ({loop_m[3], loop_m[1]} & tx_neg_i) | (~{loop_m[3], loop_m[1]} & line_rx_neg_i);
    end
  end
  ////////////////////////////////
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  chk_port_read: assert property (rd1 |-> hrdata_o[7] == 1'b0 && hrdata_o[4:0] == port_m)
    else $error("port readback wrong");
  chk_synth_pins: assert property ({synth_strobe_o, synth_clock_o, synth_data_o} == port_m[2:0]
    || {synth_strobe_o, synth_clock_o, synth_data_o} == port_q[2:0])
    else $error("synth pins differ from port");
  chk_dtr_pins: assert property (dtr_o == port_m[4:3] || dtr_o == port_q[4:3])
    else $error("dtr differs from port");
  chk_rx_enabled: assert property (line_receiver_enable_o == 2'b11)
    else $error("receiver disabled");
  chk_loop_route: assert property (rx_pos_o == exp_p && rx_neg_o == exp_n)
    else $error("loopback routing wrong");
  chk_tick_source: assert property (baud_tick_o[0] |-> hist != 4'h0)
    else $error("tick without oscillator edge");
  chk_bit_on_baud: assert property ((bit_tick_o & ~baud_tick_o) == 2'b00)
    else $error("bit tick off a generator tick");
  chk_read_wait: assert property (take && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o)
    else $error("read wait state wrong");
  cover property (rd1);
  cover property (baud_tick_o[0]);
  cover property (bit_tick_o[0] && !bit_tick_o[1]);
endmodule

bind baud_port_map baud_port_map_asserts baud_port_map_asserts_i (.clock_i, .resetn_i,
  .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hwdata_i, .hready_i, .hrdata_o, .hreadyout_o,
  .oscillator_input_i, .synth_data_o, .synth_clock_o, .synth_strobe_o, .dtr_o,
  .baud_tick_o, .bit_tick_o, .tx_pos_i, .tx_neg_i, .line_rx_pos_i, .line_rx_neg_i,
  .line_receiver_enable_o, .rx_pos_o, .rx_neg_o);

// file: tb/synth_model.sv
// Serial-programmed frequency synthesizer model.
// Pins are sampled on clock_i; output stands at 0 until loaded.
module synth_model (
  input  wire logic clock_i,
  input  wire logic data_i,
  input  wire logic sclk_i,
  input  wire logic strobe_i,
  output logic      osc_o = 1'b0
);
  timeunit 1ns;
  timeprecision 100ps;
  logic       sclk_q = 1'b0, strobe_q = 1'b0, run = 1'b0;
  logic [7:0] shift = 8'h00, count = 8'h00, half = 8'h02;
  always @(posedge clock_i) begin
    sclk_q <= sclk_i;
    strobe_q <= strobe_i;
    if (sclk_i && !sclk_q) shift <= {shift[6:0], data_i};
    // Low nibble sets the half period, kept at two clocks or more
    if (strobe_i && !strobe_q) begin
      half <= {4'h0, shift[3:0]} + 8'h02;
      count <= 8'h00;
      run <= 1'b1;
    end else if (run) begin
      count <= (count >= half - 8'h01) ? 8'h00 : count + 8'h01;
      if (count >= half - 8'h01) osc_o <= ~osc_o;
    end
  end
endmodule

// file: tb/baud_port_map_tb.sv
// Self-checking bench for baud_port_map with the synthesizer model.
// Register access is AHB-Lite; dsr inputs held at 2'b10.
module baud_port_map_tb;
  import baud_port_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] e;} reg_row_t;
  typedef struct {logic [7:0] c1, c2, c4, lo; int k;} div_row_t;
  logic        clock_i, resetn_i, hwrite_i, hrdy, hresp, osc, osc_q = 1'b0;
  logic        s_data, s_clock, s_strobe;
  logic [31:0] haddr_i, hwdata_i, hrdata, rd;
  logic [1:0]  htrans_i, dtr, b_tick, t_tick, rx_en, rx_p, rx_n, drv, lt_p, lt_n;
  logic [7:0]  stim = 8'h00;
  int          fail_count = 0, checked = 0, cycles = 0, n;
  reg_row_t    regs[7] = '{'{PORT_OFFSET, 32'hff, 32'h5f}, '{PORT_CONFIG_OFFSET, 32'he0, 32'he0},
    '{INT_PORT_OFFSET, 32'h03, 32'h03}, '{LOOPBACK_OFFSET, 32'hff, 32'h0f},
    '{8'hfc, 32'hff, 32'h00}, '{8'h40, 32'h88, 32'h88}, '{8'h4c, 32'ha5, 32'ha5}};
  div_row_t    divs[6] = '{'{8'h00, 8'h00, 8'h00, 8'h03, 1}, '{8'h00, 8'h20, 8'h00, 8'h03, 8},
    '{8'h00, 8'h60, 8'h00, 8'h01, 516}, '{8'h00, 8'he0, 8'h00, 8'hc0, 2},
    '{8'h00, 8'h60, 8'h40, 8'h42, 96}, '{8'h08, 8'h20, 8'h00, 8'h01, 4}};

  baud_port_map baud_port_map_i (.clock_i(clock_i), .resetn_i(resetn_i), .hsel_i(1'b1),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'b010),
    .hwdata_i(hwdata_i), .hready_i(hrdy), .hrdata_o(hrdata), .hreadyout_o(hrdy),
    .hresp_o(hresp), .oscillator_input_i(osc), .synth_data_o(s_data),
    .synth_clock_o(s_clock), .synth_strobe_o(s_strobe), .dtr_o(dtr), .dsr_i(2'b10),
    .baud_tick_o(b_tick), .bit_tick_o(t_tick), .tx_pos_i(stim[1:0]), .tx_neg_i(stim[3:2]),
    .tx_drive_i(stim[5:4]), .line_rx_pos_i(stim[7:6]), .line_rx_neg_i(~stim[1:0]),
    .line_tx_pos_o(lt_p), .line_tx_neg_o(lt_n), .line_driver_enable_o(drv),
    .line_receiver_enable_o(rx_en), .rx_pos_o(rx_p), .rx_neg_o(rx_n));
  synth_model synth_model_i (.clock_i(clock_i), .data_i(s_data), .sclk_i(s_clock),
    .strobe_i(s_strobe), .osc_o(osc));

  ////////////////////////////////
  task automatic final_report();
    if (fail_count == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic cmp_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmp_count(input string what, input int exp, input int got);
    checked++;
    if (got != exp) begin
      fail_count++;
      $display("Error %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  // Holds each phase until hready is sampled high
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    htrans_i <= 2'b10;
    haddr_i <= {24'h0, a};
    hwrite_i <= wr;
    do @(posedge clock_i); while (hrdy !== 1'b1);
    htrans_i <= 2'b00;
    hwdata_i <= d;
    do @(posedge clock_i); while (hrdy !== 1'b1);
    q = hrdata;
  endtask
  // First two intervals after a change are discarded as settling transients
  task automatic measure(input logic use_bit, output int cnt);
    logic t;
    repeat (3) begin
      cnt = 0;
      do begin
        @(posedge clock_i);
        t = use_bit ? t_tick[0] : b_tick[0];
        if (osc && !osc_q) cnt++;
      end while (t !== 1'b1);
    end
  endtask

  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    stim <= stim + 8'h0d;
    osc_q <= osc;
    cycles++;
    if (cycles == 80000) begin
      fail_count++;
      final_report();
    end
  end

  initial begin
    {resetn_i, hwrite_i, htrans_i, haddr_i, hwdata_i} = '0;
    repeat (20) @(posedge clock_i);
    resetn_i <= 1'b1;
    @(posedge clock_i);
    cmp_word("dtr reset", 32'h0, {30'h0, dtr});
    cmp_word("receiver enable", 32'h3, {30'h0, rx_en});
    ahb(1'b0, PORT_OFFSET, 32'h0, rd);
    cmp_word("port reset", 32'h40, rd);
    foreach (regs[i]) begin
      ahb(1'b1, regs[i].a, regs[i].w, rd);
      ahb(1'b0, regs[i].a, 32'h0, rd);
      cmp_word("register readback", regs[i].e, rd);
    end
    cmp_word("dtr set", 32'h3, {30'h0, dtr});
    cmp_word("bus response", 32'h0, {31'h0, hresp});
    @(posedge clock_i);
    rd = {24'h0, stim};
    @(posedge clock_i);
    cmp_word("line drive", {26'h0, rd[5:0]}, {26'h0, drv, lt_n, lt_p});
    // Data set up before each clock pulse, DTR 0 kept, strobe after the word
    for (int i = 7; i >= 0; i--) begin
      ahb(1'b1, PORT_OFFSET, 32'h08 | 32'(8'h01 >> i & 8'h01), rd);
      ahb(1'b1, PORT_OFFSET, 32'h0a | 32'(8'h01 >> i & 8'h01), rd);
    end
    ahb(1'b1, PORT_OFFSET, 32'h0c, rd);
    ahb(1'b1, PORT_OFFSET, 32'h08, rd);
    foreach (divs[i]) begin
      ahb(1'b1, CHANNEL_BASE + CONFIG_ONE_OFFSET, {24'h0, divs[i].c1}, rd);
      ahb(1'b1, CHANNEL_BASE + CONFIG_TWO_OFFSET, {24'h0, divs[i].c2}, rd);
      ahb(1'b1, CHANNEL_BASE + CONFIG_FOUR_OFFSET, {24'h0, divs[i].c4}, rd);
      ahb(1'b1, CHANNEL_BASE + DIVISOR_LOW_OFFSET, {24'h0, divs[i].lo}, rd);
      measure(1'b0, n);
      cmp_count("generator edges", divs[i].k, n);
      measure(1'b1, n);
      cmp_count("bit edges", divs[i].c1[3] ? 16 * divs[i].k : divs[i].k, n);
    end
    final_report();
  end
endmodule
